/* File: shared/rivm_pkg.sv */
// package: constants, offsets and state codes of the reset and interrupt vector map
package rivm_pkg;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int AW      = 17;
    localparam int VNW     = 5;
    localparam int NUM_VEC = 31;
    localparam int NUM_IRQ = 30;

    // ----------------------------------------------------------------
    // reset values and fixed addresses, in instruction words
    // ----------------------------------------------------------------
    localparam logic [AW-1:0]  BOOT_START_DEF = 17'h1F000;
    localparam logic [AW-1:0]  RESET_ADDR     = 17'h00000;
    localparam logic [AW-1:0]  VEC_STRIDE     = 17'h00002;
    localparam logic [AW-1:0]  IVT_START      = 17'h00002;
    localparam logic [VNW-1:0] VEC_RESET      = 5'h01;
    localparam logic [VNW-1:0] VEC_FIRST_IRQ  = 5'h02;
    localparam logic [VNW-1:0] VEC_WDT        = 5'h09;
    localparam logic [VNW-1:0] VEC_LAST       = 5'h1F;
    localparam logic           FUSE_UNPROG    = 1'b1;

    // ----------------------------------------------------------------
    // base-table offsets per source; request bit i sits at IVT_START + 2*i
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] OFS_EXT_PIN_0       = 17'h00002;
    localparam logic [AW-1:0] OFS_EXT_PIN_1       = 17'h00004;
    localparam logic [AW-1:0] OFS_EXT_PIN_2       = 17'h00006;
    localparam logic [AW-1:0] OFS_PIN_CHANGE_0    = 17'h00008;
    localparam logic [AW-1:0] OFS_PIN_CHANGE_1    = 17'h0000A;
    localparam logic [AW-1:0] OFS_PIN_CHANGE_2    = 17'h0000C;
    localparam logic [AW-1:0] OFS_PIN_CHANGE_3    = 17'h0000E;
    localparam logic [AW-1:0] OFS_WATCHDOG        = 17'h00010;
    localparam logic [AW-1:0] OFS_T2_COMPARE_A    = 17'h00012;
    localparam logic [AW-1:0] OFS_T2_COMPARE_B    = 17'h00014;
    localparam logic [AW-1:0] OFS_T2_OVERFLOW     = 17'h00016;
    localparam logic [AW-1:0] OFS_T1_CAPTURE      = 17'h00018;
    localparam logic [AW-1:0] OFS_T1_COMPARE_A    = 17'h0001A;
    localparam logic [AW-1:0] OFS_T1_COMPARE_B    = 17'h0001C;
    localparam logic [AW-1:0] OFS_T1_OVERFLOW     = 17'h0001E;
    localparam logic [AW-1:0] OFS_T0_COMPARE_A    = 17'h00020;
    localparam logic [AW-1:0] OFS_T0_COMPARE_B    = 17'h00022;
    localparam logic [AW-1:0] OFS_T0_OVERFLOW     = 17'h00024;
    localparam logic [AW-1:0] OFS_SERIAL_PERIPH   = 17'h00026;
    localparam logic [AW-1:0] OFS_PORT0_RX_DONE   = 17'h00028;
    localparam logic [AW-1:0] OFS_PORT0_TX_EMPTY  = 17'h0002A;
    localparam logic [AW-1:0] OFS_PORT0_TX_DONE   = 17'h0002C;
    localparam logic [AW-1:0] OFS_ANALOG_CMP      = 17'h0002E;
    localparam logic [AW-1:0] OFS_CONVERTER_DONE  = 17'h00030;
    localparam logic [AW-1:0] OFS_EEPROM_READY    = 17'h00032;
    localparam logic [AW-1:0] OFS_TWO_WIRE_DONE   = 17'h00034;
    localparam logic [AW-1:0] OFS_SELF_PROGRAM    = 17'h00036;
    localparam logic [AW-1:0] OFS_PORT1_RX_DONE   = 17'h00038;
    localparam logic [AW-1:0] OFS_PORT1_TX_EMPTY  = 17'h0003A;
    localparam logic [AW-1:0] OFS_PORT1_TX_DONE   = 17'h0003C;

    // ----------------------------------------------------------------
    // dispatch states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RIVM_S_BOOT = 2'b00,
        RIVM_S_IDLE = 2'b01,
        RIVM_S_CALC = 2'b10
    } rivm_state_t;

endpackage

/* File: tb/rivm_core_model.sv */
// core-side model: raises the accept pulse and collects the dispatched vector
`timescale 1ns/1ps
module rivm_core_model
    import rivm_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           vec_valid_r,
    input  wire logic [VNW-1:0] vec_num_r,
    input  wire logic [AW-1:0]  vec_addr_r,
    input  wire logic           watchdog_irq_flag_clr_r,
    output logic                irq_ack
);
    initial irq_ack = 1'b0;

    // ----------------------------------------------------------------
    // accept one vector
    // ----------------------------------------------------------------
    // caller enters just after a rising edge; stall models a busy core,
    // zero stall lets the accept land in the valid cycle (back to back)
    task automatic fetch(input int stall, output logic [VNW-1:0] num, output logic [AW-1:0] addr,
                         output logic clr, output bit ok);
        ok = 1'b0;
        num = '0;
        addr = '0;
        clr = 1'b0;
        repeat (stall) @(posedge mclk);
        if (stall > 0) #1;
        irq_ack = 1'b1;
        @(posedge mclk);
        #1;
        irq_ack = 1'b0;
        // answer is due two edges after the accept; a little slack, no more
        for (int k = 0; k < 4 && !ok; k++) begin
            @(posedge mclk);
            #1;
            if (vec_valid_r === 1'b1) begin
                ok = 1'b1;
                num = vec_num_r;
                addr = vec_addr_r;
                clr = watchdog_irq_flag_clr_r;
            end
        end
    endtask
endmodule

/* File: tb/rivm_top_test.sv */
// self-checking bench for the reset and interrupt vector map
`timescale 1ns/1ps
module rivm_top_test
    import rivm_pkg::*;
;
    logic                 mclk;
    logic                 rstn;
    logic                 boot_reset_fuse;
    logic                 vector_table_select;
    logic [NUM_IRQ-1:0]   irq_req;
    logic                 irq_ack;
    logic                 irq_pending_r;
    logic                 vec_valid_r;
    logic [VNW-1:0]       vec_num_r;
    logic [AW-1:0]        vec_addr_r;
    logic                 watchdog_irq_flag_clr_r;
    int                   n_mismatch;
    int                   cmp_count;

    always #25 mclk = ~mclk;

    rivm_top #(.BOOT_START(BOOT_START_DEF), .N_IRQ(NUM_IRQ)) dut_u (
        .mclk                    (mclk),
        .rstn                    (rstn),
        .boot_reset_fuse         (boot_reset_fuse),
        .vector_table_select     (vector_table_select),
        .irq_req                 (irq_req),
        .irq_ack                 (irq_ack),
        .irq_pending_r           (irq_pending_r),
        .vec_valid_r             (vec_valid_r),
        .vec_num_r               (vec_num_r),
        .vec_addr_r              (vec_addr_r),
        .watchdog_irq_flag_clr_r (watchdog_irq_flag_clr_r)
    );

    rivm_core_model core_u (
        .mclk                    (mclk),
        .vec_valid_r             (vec_valid_r),
        .vec_num_r               (vec_num_r),
        .vec_addr_r              (vec_addr_r),
        .watchdog_irq_flag_clr_r (watchdog_irq_flag_clr_r),
        .irq_ack                 (irq_ack)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    function automatic logic [AW-1:0] vaddr(input logic [VNW-1:0] v, input logic sel);
        return (sel ? BOOT_START_DEF : RESET_ADDR) + AW'(2 * (v - 1));
    endfunction

    task automatic take(input int stall, input logic [VNW-1:0] en, input logic [AW-1:0] ea);
        logic [VNW-1:0] num;
        logic [AW-1:0]  addr;
        logic           clr;
        bit             ok;
        core_u.fetch(stall, num, addr, clr, ok);
        if (!ok) begin
            $display("unexpected vec_valid_r: expected 1 seen 0");
            n_mismatch++;
            complete_run();
        end
        check("vec_num_r", 32'(en), 32'(num));
        check("vec_addr_r", 32'(ea), 32'(addr));
        check("watchdog_irq_flag_clr_r", 32'(en == VEC_WDT), 32'(clr));
    endtask

    // reset pulse, then wait (bounded) for the reset vector announcement
    task automatic rst_pulse(input int n);
        bit seen;
        seen = 1'b0;
        @(posedge mclk);
        #1;
        rstn = 1'b0;
        repeat (n) @(posedge mclk);
        #1;
        rstn = 1'b1;
        for (int k = 0; k < 5 && !seen; k++) begin
            @(posedge mclk);
            #1;
            seen = (vec_valid_r === 1'b1);
        end
        if (!seen) begin
            $display("unexpected vec_valid_r after reset: expected 1 seen 0");
            n_mismatch++;
            complete_run();
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_combos();
        for (int j = 0; j < 4; j++) begin
            boot_reset_fuse = (j < 2);
            vector_table_select = j[0];
            rst_pulse(j == 0 ? 20 : 2);
            check("vec_num_r", 32'(VEC_RESET), 32'(vec_num_r));
            check("vec_addr_r", 32'(boot_reset_fuse ? RESET_ADDR : BOOT_START_DEF), 32'(vec_addr_r));
            irq_req[0] = 1'b1;
            take(1, VEC_FIRST_IRQ, (j[0] ? BOOT_START_DEF : RESET_ADDR) + IVT_START);
            irq_req = '0;
        end
        $display("test reset_combos done");
    endtask

    task automatic t_all_sources(input logic sel);
        vector_table_select = sel;
        @(posedge mclk);
        #1;
        for (int i = 0; i < NUM_IRQ; i++) begin
            irq_req = '0;
            irq_req[i] = 1'b1;
            // each source's base offset sits two words past its neighbour
            take(0, VNW'(i + 2), vaddr(VNW'(i + 2), sel));
            check("irq_pending_r", 32'h1, 32'(irq_pending_r));
        end
        irq_req = '0;
        $display("test all_sources done");
    endtask

    task automatic t_priority_refuse();
        vector_table_select = 1'b0;
        irq_req = '0;
        irq_req[5] = 1'b1;
        irq_req[20] = 1'b1;
        irq_req[29] = 1'b1;
        take(2, 5'h07, vaddr(5'h07, 1'b0));
        irq_req[5] = 1'b0;
        take(0, 5'h16, vaddr(5'h16, 1'b0));
        irq_req[20] = 1'b0;
        take(0, VEC_LAST, OFS_PORT1_TX_DONE);
        irq_req = '0;
        repeat (2) @(posedge mclk);
        #1;
        check("irq_pending_r", 32'h0, 32'(irq_pending_r));
        // an accept with nothing pending must not announce anything
        begin
            logic [VNW-1:0] num;
            logic [AW-1:0]  addr;
            logic           clr;
            bit             ok;
            core_u.fetch(0, num, addr, clr, ok);
            check("vec_valid_r seen", 32'h0, 32'(ok));
            check("vec_num_r", 32'(VEC_LAST), 32'(vec_num_r));
        end
        $display("test priority_refuse done");
    endtask

    task automatic t_select_move();
        vector_table_select = 1'b0;
        boot_reset_fuse = 1'b1;
        irq_req[2] = 1'b1;
        take(1, 5'h04, OFS_EXT_PIN_2);
        irq_req = '0;
        vector_table_select = 1'b1;
        @(posedge mclk);
        #1;
        check("vec_addr_r", 32'(BOOT_START_DEF + OFS_EXT_PIN_2), 32'(vec_addr_r));
        boot_reset_fuse = 1'b0;
        @(posedge mclk);
        #1;
        check("vec_addr_r", 32'(BOOT_START_DEF + OFS_EXT_PIN_2), 32'(vec_addr_r));
        vector_table_select = 1'b0;
        @(posedge mclk);
        #1;
        check("vec_addr_r", 32'(OFS_EXT_PIN_2), 32'(vec_addr_r));
        boot_reset_fuse = 1'b1;
        $display("test select_move done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        boot_reset_fuse = 1'b1;
        vector_table_select = 1'b0;
        irq_req = '0;
        n_mismatch = 0;
        cmp_count = 0;
        t_reset_combos();
        t_all_sources(1'b0);
        t_all_sources(1'b1);
        t_priority_refuse();
        t_select_move();
        complete_run();
    end
endmodule

/* File: verilog/rivm_top.sv */
// reset and interrupt vector map: picks a request and presents its fetch address
//
// Function
// - each vector spans two instruction words; neighbouring addresses differ by two
// - reset fetches at zero with fuse unprogrammed, else at boot start
// - select bit set moves the interrupt table to the boot section start
// - relocated vector address is base-table address plus boot start
// - vectors begin at two, or boot start plus two; reset follows fuse
// - reset location and table location are chosen independently
// - pin, power-on, brown-out and watchdog resets share vector one
// - external pin requests 0..2 use offsets 0x02, 0x04, 0x06
// - pin-change requests 0..3 use offsets 0x08 to 0x0E
// - timer 2 compare a, compare b, overflow use 0x12, 0x14, 0x16
// - timer 1 capture, compare a, compare b, overflow use 0x18 to 0x1E
// - timer 0 compare a, compare b, overflow use 0x20, 0x22, 0x24
// - serial peripheral transfer done uses offset 0x26, vector 20
// - first serial port rx done, tx empty, tx done use 0x28 to 0x2C
// - self-programming ready uses offset 0x36, vector 28
// - second serial port rx done, tx empty, tx done use 0x38 to 0x3C
// - watchdog 0x10, comparator 0x2E, converter 0x30, eeprom 0x32, two-wire 0x34
// - fuse value one means unprogrammed, zero means programmed
// - dispatching the watchdog vector clears the watchdog flag in hardware
`timescale 1ns/1ps
module rivm_top
    import rivm_pkg::*;
#(
    parameter logic [AW-1:0] BOOT_START = BOOT_START_DEF,
    parameter int            N_IRQ      = NUM_IRQ
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              boot_reset_fuse,
    input  wire logic              vector_table_select,
    input  wire logic [N_IRQ-1:0]  irq_req,
    input  wire logic              irq_ack,
    output logic                   irq_pending_r,
    output logic                   vec_valid_r,
    output logic      [VNW-1:0]    vec_num_r,
    output logic      [AW-1:0]     vec_addr_r,
    output logic                   watchdog_irq_flag_clr_r
);

    rivm_state_t    state_r;
    rivm_state_t    state_nxt;
    logic [VNW-1:0] win_w;
    logic           any_req_w;
    logic           take_w;

    // ----------------------------------------------------------------
    // request selection
    // ----------------------------------------------------------------
    // lowest vector number wins, so the loop runs downward and the last hit stays
    always_comb begin
        win_w = VEC_FIRST_IRQ;
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (irq_req[i]) begin
                win_w = VNW'(i + 2);
            end
        end
    end

    assign any_req_w = |irq_req;
    assign take_w    = (state_r == RIVM_S_IDLE) && irq_ack && any_req_w;

    // ----------------------------------------------------------------
    // dispatch state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            RIVM_S_BOOT: begin
                state_nxt = RIVM_S_CALC;
            end
            RIVM_S_IDLE: begin
                if (take_w) begin
                    state_nxt = RIVM_S_CALC;
                end
            end
            RIVM_S_CALC: begin
                state_nxt = RIVM_S_IDLE;
            end
            default: begin
                state_nxt = RIVM_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= RIVM_S_BOOT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // every reset cause comes back here through rstn, hence one shared vector
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            vec_num_r <= VEC_RESET;
        end else if (take_w) begin
            vec_num_r <= win_w;
        end
    end

    // ----------------------------------------------------------------
    // address calculation
    // ----------------------------------------------------------------
    rivm_vec_addr #(
        .BOOT_START (BOOT_START)
    ) u_vec_addr (
        .mclk                (mclk),
        .rstn                (rstn),
        .vec_num             (vec_num_r),
        .boot_reset_fuse     (boot_reset_fuse),
        .vector_table_select (vector_table_select),
        .vec_addr_r          (vec_addr_r)
    );

    // ----------------------------------------------------------------
    // outputs toward the core
    // ----------------------------------------------------------------
    // valid lands together with the address, which takes one edge to settle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            vec_valid_r <= 1'b0;
        end else begin
            vec_valid_r <= (state_r == RIVM_S_CALC);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            watchdog_irq_flag_clr_r <= 1'b0;
        end else begin
            watchdog_irq_flag_clr_r <= (state_r == RIVM_S_CALC) && (vec_num_r == VEC_WDT);
        end
    end

    // pending lags the requests by one edge; a stale ack is simply ignored
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_pending_r <= 1'b0;
        end else begin
            irq_pending_r <= any_req_w;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking chk_cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    logic [AW-1:0] exp_off_w;
    assign exp_off_w = AW'({vec_num_r - VEC_RESET, 1'b0});

    chk_stride_two: assert property (
        (vec_valid_r && vec_num_r > VEC_RESET && !$past(vector_table_select))
            |-> (vec_addr_r == exp_off_w) && (vec_addr_r[0] == 1'b0)
    ) else $error("vector address is not two words per vector");

    chk_reset_fuse_sel: assert property (
        (vec_valid_r && vec_num_r == VEC_RESET)
            |-> vec_addr_r == ($past(boot_reset_fuse) ? RESET_ADDR : BOOT_START)
    ) else $error("reset address does not follow the boot fuse");

    chk_fuse_polarity: assert property (
        (vec_valid_r && vec_num_r == VEC_RESET && !$past(boot_reset_fuse))
            |-> vec_addr_r == BOOT_START
    ) else $error("programmed fuse did not select the boot start");

    chk_table_reloc: assert property (
        (vec_valid_r && vec_num_r == VEC_FIRST_IRQ && $past(vector_table_select))
            |-> vec_addr_r == BOOT_START + IVT_START
    ) else $error("relocated table does not start at boot start plus two");

    chk_reloc_sum: assert property (
        (vec_valid_r && vec_num_r > VEC_RESET && $past(vector_table_select))
            |-> vec_addr_r == BOOT_START + exp_off_w
    ) else $error("relocated vector is not base plus boot start");

    chk_table_start: assert property (
        (vec_valid_r && vec_num_r == VEC_FIRST_IRQ && !$past(vector_table_select))
            |-> vec_addr_r == IVT_START
    ) else $error("interrupt table does not start at two");

    chk_reset_indep: assert property (
        (vec_valid_r && vec_num_r == VEC_RESET && $past(boot_reset_fuse)
            && $past(vector_table_select))
            |-> vec_addr_r == RESET_ADDR
    ) else $error("table select moved the reset address");

    chk_boot_vector: assert property (
        (state_r == RIVM_S_BOOT)
            |-> ##2 (vec_valid_r && vec_num_r == VEC_RESET)
    ) else $error("reset vector not presented after reset");

    chk_ext_pin_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == 5'h04)
            |-> vec_addr_r == OFS_EXT_PIN_2
    ) else $error("external pin request 2 address wrong");

    chk_pin_chg_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == 5'h08)
            |-> vec_addr_r == OFS_PIN_CHANGE_3
    ) else $error("pin change request 3 address wrong");

    chk_t2_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == 5'h0C)
            |-> vec_addr_r == OFS_T2_OVERFLOW
    ) else $error("timer 2 overflow address wrong");

    chk_t1_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == 5'h0D)
            |-> vec_addr_r == OFS_T1_CAPTURE
    ) else $error("timer 1 capture address wrong");

    chk_t0_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == 5'h13)
            |-> vec_addr_r == OFS_T0_OVERFLOW
    ) else $error("timer 0 overflow address wrong");

    chk_spi_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == 5'h14)
            |-> vec_addr_r == OFS_SERIAL_PERIPH
    ) else $error("serial peripheral done address wrong");

    chk_port0_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == 5'h17)
            |-> vec_addr_r == OFS_PORT0_TX_DONE
    ) else $error("first serial port tx done address wrong");

    chk_selfprog_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == 5'h1C)
            |-> vec_addr_r == OFS_SELF_PROGRAM
    ) else $error("self programming ready address wrong");

    chk_port1_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == VEC_LAST)
            |-> vec_addr_r == OFS_PORT1_TX_DONE
    ) else $error("second serial port tx done address wrong");

    chk_misc_map: assert property (
        (vec_valid_r && !$past(vector_table_select) && vec_num_r == 5'h1B)
            |-> vec_addr_r == OFS_TWO_WIRE_DONE
    ) else $error("two wire done address wrong");

    chk_wdt_flag_clr: assert property (
        watchdog_irq_flag_clr_r == (vec_valid_r && vec_num_r == VEC_WDT)
    ) else $error("watchdog flag clear not tied to its dispatch");

    chk_select_follow: assert property (
        ($changed(vector_table_select) && vec_num_r > VEC_RESET && $stable(vec_num_r))
            |=> vec_addr_r == ($past(vector_table_select) ? BOOT_START + exp_off_w : exp_off_w)
    ) else $error("address not recomputed after select change");

    chk_ack_dispatch: assert property (
        take_w |-> ##2 (vec_valid_r && vec_num_r == $past(win_w, 2))
    ) else $error("accepted request not dispatched in two edges");

    cov_boot_programmed: cover property (
        vec_valid_r && vec_num_r == VEC_RESET && !boot_reset_fuse
    );

    cov_reloc_dispatch: cover property (
        vec_valid_r && vec_num_r > VEC_RESET && vector_table_select
    );

    cov_wdt_dispatch: cover property (
        watchdog_irq_flag_clr_r
    );

    cov_select_change: cover property (
        state_r == RIVM_S_IDLE && $changed(vector_table_select)
    );

endmodule

/* File: verilog/rivm_vec_addr.sv */
// vector address register: reset address or table base plus twice (vector - 1)
`timescale 1ns/1ps
module rivm_vec_addr
    import rivm_pkg::*;
#(
    parameter logic [AW-1:0] BOOT_START = BOOT_START_DEF
) (
    input  wire logic            mclk,
    input  wire logic            rstn,
    input  wire logic [VNW-1:0]  vec_num,
    input  wire logic            boot_reset_fuse,
    input  wire logic            vector_table_select,
    output logic      [AW-1:0]   vec_addr_r
);

    logic [AW-1:0] offset_w;
    logic [AW-1:0] vec_addr_nxt;

    // ----------------------------------------------------------------
    // address arithmetic
    // ----------------------------------------------------------------
    always_comb begin
        offset_w = AW'({vec_num - VEC_RESET, 1'b0});
        if (vec_num == VEC_RESET) begin
            // reset looks at the fuse only, never at the table select
            vec_addr_nxt = (boot_reset_fuse == FUSE_UNPROG) ? RESET_ADDR : BOOT_START;
        end else if (vector_table_select) begin
            vec_addr_nxt = BOOT_START + offset_w;
        end else begin
            vec_addr_nxt = offset_w;
        end
    end

    // recomputed every cycle so a select change shows one edge later
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            vec_addr_r <= RESET_ADDR;
        end else begin
            vec_addr_r <= vec_addr_nxt;
        end
    end

endmodule
